// ---- bbfc_ctrl.sv ----
// Backlight boost control: automatic switching frequency, load-shed
// brightness override and overvoltage / open-string fault handling.
// Assumes a register port with read data one cycle after the strobe,
// and comparator inputs already synchronous to ref_clk.
//
// The placing of the registers and the plain strobed port are this design's own decisions.

`timescale 1ns/10ps

module bbfc_ctrl #(
  parameter int OVP_LIMIT = bbfc_pkg::OVP_CYCLES
) (
  input  wire logic                 ref_clk,          // 100 MHz clock
  input  wire logic                 rst_n,            // Synchronous reset, active low
  input  wire logic [7:0]           reg_addr,         // Register address
  input  wire logic [7:0]           reg_wdata,        // Register write data
  input  wire logic                 reg_wr,           // Write strobe
  input  wire logic                 reg_rd,           // Read strobe
  output logic [7:0]                reg_rdata,        // Read data, cycle after strobe
  input  wire logic                 load_shed_input,  // Load-shed pin
  input  wire logic                 ovp_over,         // Output above limit
  input  wire logic                 ovp_below_hyst,   // Output 1 V below limit
  input  wire logic                 string_one_sink_low, // Sink one at or below 40 mV
  input  wire logic                 string_two_sink_low, // Sink two at or below 40 mV
  output logic [10:0]               mapper_code,      // Brightness code to mapper
  output logic [1:0]                string_en,        // Enabled strings
  output logic                      device_on,        // Device running
  output bbfc_pkg::bbfc_boost_t     boost             // Boost control bundle
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  initial
  begin
    if (OVP_LIMIT < 1)
      $error("OVP_LIMIT must be at least 1");
    if (OVP_LIMIT > 2 ** 30)
      $error("OVP_LIMIT too large for the duration timer");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] enable_r;
  logic [7:0] brt_ctrl_r;
  logic [7:0] boost_r;
  logic [7:0] af_high_r;
  logic [7:0] af_low_r;
  logic [7:0] shed_thr_r;
  logic [2:0] brt_lsb_stage_r;
  logic [2:0] brt_lsb_r;
  logic [7:0] brt_msb_r;
  logic [7:0] fault_ctl_r;
  logic       flag_ovp_r;
  logic       flag_open_r;
  logic       lockout_r;
  logic       boost_hold_r;
  logic       ovp_over_d_r;
  logic [1:0] open_hits_r;
  logic [7:0] rdata_r;
  logic [10:0] code_r;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // One compare shared by every strobe decode
  function automatic logic addr_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  wire wr_enable   = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_ENABLE);
  wire wr_brt_ctrl = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_BRT_CTRL);
  wire wr_boost    = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_BOOST);
  wire wr_af_high  = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_AF_HIGH);
  wire wr_af_low   = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_AF_LOW);
  wire wr_shed     = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_SHED_THR);
  wire wr_lsb      = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_BRT_LSB);
  wire wr_msb      = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_BRT_MSB);
  wire wr_fctl     = addr_hit(reg_wr, reg_addr, bbfc_pkg::ADDR_FAULT_CTL);
  wire rd_fault    = addr_hit(reg_rd, reg_addr, bbfc_pkg::ADDR_FAULT);

  // ----------------------------------------
  // Automatic switching frequency
  // ----------------------------------------
  wire auto_mode  = (af_high_r != bbfc_pkg::RST_ZERO) ||
                    (af_low_r != bbfc_pkg::RST_ZERO);
  wire below_low  = (brt_msb_r < af_low_r);
  wire at_or_high = (brt_msb_r >= af_high_r);
  wire prog_1m    = boost_r[bbfc_pkg::BOOST_FREQ];

  bbfc_pkg::bbfc_freq_t auto_freq;
  bbfc_pkg::bbfc_freq_t freq_sel;

  // Low comparison first: equal to low falls through to the high-threshold compare
  assign auto_freq = below_low  ? bbfc_pkg::BBFC_F250K :
                     at_or_high ? bbfc_pkg::BBFC_F1M   :
                                  bbfc_pkg::BBFC_F500K;
  assign freq_sel  = auto_mode ? auto_freq :
                     (prog_1m ? bbfc_pkg::BBFC_F1M : bbfc_pkg::BBFC_F500K);

  // ----------------------------------------
  // Load-shed override
  // ----------------------------------------
  wire        shed_active = load_shed_input ^ brt_ctrl_r[bbfc_pkg::SHED_POL_BIT];
  wire [10:0] brt_code    = {brt_msb_r, brt_lsb_r};
  wire [10:0] shed_code   = {shed_thr_r, bbfc_pkg::SHED_LSB};
  wire        shed_lower  = shed_code < brt_code;
  // Combinational swap reaches the mapper within one cycle, far under 50 us
  wire [10:0] code_nxt    = (shed_active && shed_lower) ? shed_code : brt_code;

  // ----------------------------------------
  // Overvoltage detection
  // ----------------------------------------
  // Disabled strings are ignored so an unused sink cannot fake an open
  wire sink_low  = (enable_r[bbfc_pkg::EN_STR1_BIT] && string_one_sink_low) ||
                   (enable_r[bbfc_pkg::EN_STR2_BIT] && string_two_sink_low);
  wire ovp_rise  = ovp_over && !ovp_over_d_r;
  wire ovp_long;
  wire open_hit  = ovp_rise && sink_low;
  wire third_hit = open_hit && (open_hits_r == bbfc_pkg::OPEN_HITS - 2'h1);
  wire set_ovp   = ovp_long || third_hit;
  wire set_open  = (ovp_long && sink_low) || third_hit;
  wire flag_ovp_nxt  = set_ovp || (flag_ovp_r && !rd_fault);
  wire flag_open_nxt = set_open || (flag_open_r && !rd_fault);
  wire trip      = set_ovp && fault_ctl_r[bbfc_pkg::OVP_SD_BIT];
  // Trip and a pending lockout both outrank a host write of the enable bit
  wire en_block   = trip || (lockout_r && !rd_fault);
  wire en_host    = wr_enable ? reg_wdata[bbfc_pkg::EN_DEV_BIT] :
                                enable_r[bbfc_pkg::EN_DEV_BIT];
  wire dev_en_nxt = en_block ? 1'b0 : en_host;

  // Timer restarts on every dip so only a continuous excursion counts
  bbfc_ovp_timer #(
    .LIMIT (OVP_LIMIT)
  ) u_ovp_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .active  (ovp_over),
    .expired (ovp_long)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped offsets read as zero
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = bbfc_pkg::RST_ZERO;
    unique case (reg_addr)
      bbfc_pkg::ADDR_ENABLE:    rd_mux = enable_r;
      bbfc_pkg::ADDR_BRT_CTRL:  rd_mux = brt_ctrl_r;
      bbfc_pkg::ADDR_BOOST:     rd_mux = boost_r;
      bbfc_pkg::ADDR_AF_HIGH:   rd_mux = af_high_r;
      bbfc_pkg::ADDR_AF_LOW:    rd_mux = af_low_r;
      bbfc_pkg::ADDR_SHED_THR:  rd_mux = shed_thr_r;
      bbfc_pkg::ADDR_BRT_LSB:   rd_mux = {5'h0_0, brt_lsb_stage_r};
      bbfc_pkg::ADDR_BRT_MSB:   rd_mux = brt_msb_r;
      bbfc_pkg::ADDR_FAULT_CTL: rd_mux = fault_ctl_r;
      bbfc_pkg::ADDR_FAULT:
      begin
        rd_mux[bbfc_pkg::FLT_OVP_BIT]  = flag_ovp_r;
        rd_mux[bbfc_pkg::FLT_OPEN_BIT] = flag_open_r;
      end
      default:                  rd_mux = bbfc_pkg::RST_ZERO;
    endcase
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      brt_ctrl_r  <= bbfc_pkg::RST_ZERO;
      boost_r     <= bbfc_pkg::RST_ZERO;
      af_high_r   <= bbfc_pkg::RST_ZERO;
      af_low_r    <= bbfc_pkg::RST_ZERO;
      shed_thr_r  <= bbfc_pkg::RST_ZERO;
      fault_ctl_r <= bbfc_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_brt_ctrl)
        brt_ctrl_r <= reg_wdata;
      if (wr_boost)
        boost_r <= reg_wdata;
      if (wr_af_high)
        af_high_r <= reg_wdata;
      if (wr_af_low)
        af_low_r <= reg_wdata;
      if (wr_shed)
        shed_thr_r <= reg_wdata;
      if (wr_fctl)
        fault_ctl_r <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Enable and brightness
  // ----------------------------------------
  // Low bits are staged; the code moves only when the upper byte lands
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      enable_r        <= bbfc_pkg::RST_ENABLE;
      brt_lsb_stage_r <= bbfc_pkg::RST_LSB3;
      brt_lsb_r       <= bbfc_pkg::RST_LSB3;
      brt_msb_r       <= bbfc_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_enable)
        enable_r[bbfc_pkg::EN_STR2_BIT:bbfc_pkg::EN_STR1_BIT] <=
          reg_wdata[bbfc_pkg::EN_STR2_BIT:bbfc_pkg::EN_STR1_BIT];
      enable_r[bbfc_pkg::EN_DEV_BIT] <= dev_en_nxt;
      if (wr_lsb)
        brt_lsb_stage_r <= reg_wdata[2:0];
      if (wr_msb)
      begin
        brt_msb_r <= reg_wdata;
        brt_lsb_r <= brt_lsb_stage_r;
      end
    end
  end

  // ----------------------------------------
  // Mapper code
  // ----------------------------------------
  // Deasserting load-shed falls back to the live brightness code
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      code_r <= '0;
    else
      code_r <= code_nxt;
  end

  // ----------------------------------------
  // Overvoltage hysteresis
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      boost_hold_r <= 1'b0;
      ovp_over_d_r <= 1'b0;
    end
    else
    begin
      ovp_over_d_r <= ovp_over;
      if (ovp_over)
        boost_hold_r <= 1'b1;
      else if (ovp_below_hyst)
        boost_hold_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Fault flags and lockout
  // ----------------------------------------
  // Set wins over the read-clear so a coincident event is kept
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flag_ovp_r  <= 1'b0;
      flag_open_r <= 1'b0;
      lockout_r   <= 1'b0;
      open_hits_r <= 2'h0;
    end
    else
    begin
      flag_ovp_r  <= flag_ovp_nxt;
      flag_open_r <= flag_open_nxt;
      if (trip)
        lockout_r <= 1'b1;
      else if (rd_fault)
        lockout_r <= 1'b0;
      if (third_hit || (rd_fault && !open_hit))
        open_hits_r <= 2'h0;
      else if (open_hit)
        open_hits_r <= open_hits_r + 2'h1;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Zero outside the slot so a stale value is never taken as fresh
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_r <= bbfc_pkg::RST_ZERO;
    else if (reg_rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= bbfc_pkg::RST_ZERO;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata   = rdata_r;
  assign mapper_code = code_r;
  assign device_on   = enable_r[bbfc_pkg::EN_DEV_BIT] && !lockout_r;
  assign string_en   = enable_r[bbfc_pkg::EN_STR2_BIT:bbfc_pkg::EN_STR1_BIT];

  // Flag alone does not stop the boost unless shutdown is armed
  assign boost.freq      = freq_sel;
  assign boost.shift     = boost_r[bbfc_pkg::BOOST_SHIFT];
  assign boost.duty_half = (freq_sel == bbfc_pkg::BBFC_F250K);
  assign boost.min_ind   = boost_r[bbfc_pkg::BOOST_MININD];
  assign boost.ovp_level = boost_r[bbfc_pkg::BOOST_OVP_LO +: 2];
  assign boost.run       = device_on && !boost_hold_r;
endmodule

// ---- bbfc_ctrl_assertions.sv ----
// Concurrent checks on the boost control block, bound to bbfc_ctrl.
// Assumes one clock domain and the top ports only.
`timescale 1ns/10ps

module bbfc_ctrl_chk #(
  parameter int OVP_LIMIT = bbfc_pkg::OVP_CYCLES
) (
  input wire logic                  ref_clk,             // Clock
  input wire logic                  rst_n,               // Sync reset, low
  input wire logic [7:0]            reg_addr,            // Address
  input wire logic [7:0]            reg_wdata,           // Write data
  input wire logic                  reg_wr,              // Write strobe
  input wire logic                  reg_rd,              // Read strobe
  input wire logic [7:0]            reg_rdata,           // Read data
  input wire logic                  load_shed_input,     // Load-shed pin
  input wire logic                  ovp_over,            // Above limit
  input wire logic                  ovp_below_hyst,      // Below hysteresis
  input wire logic                  string_one_sink_low, // Sink one low
  input wire logic                  string_two_sink_low, // Sink two low
  input wire logic [10:0]           mapper_code,         // Mapper code
  input wire logic [1:0]            string_en,           // String enables
  input wire logic                  device_on,           // Running
  input wire bbfc_pkg::bbfc_boost_t boost                // Boost bundle
);
  default clocking
    @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Shadows of the two frequency thresholds and the brightness upper byte, taken from the bus
  logic [7:0] hi_sh;
  logic [7:0] lo_sh;
  logic [7:0] msb_sh;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hi_sh  <= 8'h00;
      lo_sh  <= 8'h00;
      msb_sh <= 8'h00;
    end
    else if (reg_wr && reg_addr == bbfc_pkg::ADDR_AF_HIGH)
      hi_sh <= reg_wdata;
    else if (reg_wr && reg_addr == bbfc_pkg::ADDR_AF_LOW)
      lo_sh <= reg_wdata;
    else if (reg_wr && reg_addr == bbfc_pkg::ADDR_BRT_MSB)
      msb_sh <= reg_wdata;
  end

  a_f250_auto_only: assert property (boost.freq == bbfc_pkg::BBFC_F250K |->
    (hi_sh != 8'h00 || lo_sh != 8'h00) && msb_sh < lo_sh)
    else $error("lowest frequency outside automatic mode or above low threshold");
  a_flag_clear_gap: assert property ((reg_rd && reg_addr == bbfc_pkg::ADDR_FAULT && !ovp_over)
    ##1 !ovp_over ##1 (reg_rd && reg_addr == bbfc_pkg::ADDR_FAULT && !ovp_over)
    |=> reg_rdata == 8'h00)
    else $error("fault flags not cleared by an earlier read");

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  a_duty_half: assert property (boost.duty_half == (boost.freq == bbfc_pkg::BBFC_F250K))
    else $error("duty limit does not follow the lowest frequency");
  a_freq_source: assert property ($changed(boost.freq) |-> $past(reg_wr)
    && $past(reg_addr) inside {8'h13, 8'h15, 8'h16, 8'h19})
    else $error("frequency moved without a relevant write");
  a_ovp_level_src: assert property ($changed(boost.ovp_level) |-> $past(reg_wr)
    && $past(reg_addr) == bbfc_pkg::ADDR_BOOST)
    else $error("overvoltage level moved without a boost write");
  a_run_drop: assert property ($rose(ovp_over) |=> !boost.run)
    else $error("boost kept running above the limit");
  a_run_resume: assert property ($rose(boost.run) |-> !$past(ovp_over))
    else $error("boost resumed while above the limit");
  a_off_no_run: assert property (!device_on |-> !boost.run)
    else $error("boost runs while device is off");
  a_dev_fall: assert property ($fell(device_on) |-> $past(reg_wr) || $past(ovp_over))
    else $error("device switched off without cause");
  a_flag_clear: assert property ((reg_rd && reg_addr == 8'h1F && !ovp_over) ##1
    (reg_rd && reg_addr == 8'h1F && !ovp_over) |=> reg_rdata == 8'h00)
    else $error("fault flags not cleared by read");
endmodule

bind bbfc_ctrl bbfc_ctrl_chk #(.OVP_LIMIT(OVP_LIMIT)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .load_shed_input(load_shed_input), .ovp_over(ovp_over), .ovp_below_hyst(ovp_below_hyst),
  .string_one_sink_low(string_one_sink_low), .string_two_sink_low(string_two_sink_low),
  .mapper_code(mapper_code), .string_en(string_en), .device_on(device_on), .boost(boost)
);

// ---- bbfc_host_model.sv ----
// Host processor model: register port master and load-shed pin driver.
// Assumes strobes sampled on the rising edge, no wait states.
`timescale 1ns/10ps

module bbfc_host_model (
  input  wire logic  ref_clk,         // Clock
  output logic [7:0] reg_addr,        // Address
  output logic [7:0] reg_wdata,       // Write data
  output logic       reg_wr,          // Write strobe
  output logic       reg_rd,          // Read strobe
  output logic       load_shed_input  // Load-shed pin
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    load_shed_input = 1'b0;
  end

  // Idle bus shows inverted data so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask

  task automatic shed(input logic v);
    @(posedge ref_clk);
    load_shed_input <= v;
  endtask

  task automatic set_inductor(input logic big);
    wr(8'h13, {3'b000, big, 4'b0000});
  endtask

  // Caller waits the scaled settle time, then reads the flags
  task automatic open_test;
    wr(8'h10, 8'h07);
    wr(8'h18, 8'h07);
    wr(8'h19, 8'hFF);
    wr(8'h11, 8'h00);
  endtask
endmodule

// ---- bbfc_ovp_timer.sv ----
// Package for the backlight boost frequency and fault control block,
// plus the overvoltage duration timer that the main module instantiates.
// Assumes one 100 MHz clock and comparator levels synchronous to it.

package bbfc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_ENABLE    = 8'h10;
  localparam logic [7:0] ADDR_BRT_CTRL  = 8'h11;
  localparam logic [7:0] ADDR_BOOST     = 8'h13;
  localparam logic [7:0] ADDR_AF_HIGH   = 8'h15;
  localparam logic [7:0] ADDR_AF_LOW    = 8'h16;
  localparam logic [7:0] ADDR_SHED_THR  = 8'h17;
  localparam logic [7:0] ADDR_BRT_LSB   = 8'h18;
  localparam logic [7:0] ADDR_BRT_MSB   = 8'h19;
  localparam logic [7:0] ADDR_FAULT_CTL = 8'h1E;
  localparam logic [7:0] ADDR_FAULT     = 8'h1F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EN_DEV_BIT     = 0;
  localparam int EN_STR1_BIT    = 1;
  localparam int EN_STR2_BIT    = 2;
  localparam int SHED_POL_BIT   = 0;
  localparam int BOOST_SHIFT    = 6;
  localparam int BOOST_FREQ     = 5;
  localparam int BOOST_MININD   = 4;
  localparam int BOOST_OVP_LO   = 2;
  localparam int OVP_SD_BIT     = 0;
  localparam int FLT_OVP_BIT    = 0;
  localparam int FLT_OPEN_BIT   = 4;

  // ----------------------------------------
  // Reset values and fixed constants
  // ----------------------------------------
  localparam logic [7:0]  RST_ENABLE  = 8'h07;
  localparam logic [7:0]  RST_ZERO    = 8'h00;
  localparam logic [2:0]  RST_LSB3    = 3'h0;
  localparam logic [2:0]  SHED_LSB    = 3'h0;
  localparam logic [1:0]  OPEN_HITS   = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int OVP_TIME_US  = 1000;
  localparam int OVP_CYCLES   = OVP_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    BBFC_F250K = 2'b00,
    BBFC_F500K = 2'b01,
    BBFC_F1M   = 2'b10
  } bbfc_freq_t;

  // Boost control outputs travel together
  typedef struct packed {
    bbfc_freq_t freq;
    logic       shift;
    logic       duty_half;
    logic       min_ind;
    logic [1:0] ovp_level;
    logic       run;
  } bbfc_boost_t;
endpackage

`timescale 1ns/10ps

module bbfc_ovp_timer #(
  parameter int LIMIT = bbfc_pkg::OVP_CYCLES
) (
  input  wire logic ref_clk, // 100 MHz clock
  input  wire logic rst_n,   // Synchronous reset, active low
  input  wire logic active,  // Condition being timed
  output logic      expired  // One-cycle pulse in the LIMIT-th consecutive active cycle
);
  localparam int W = $clog2(LIMIT + 1);

  initial
  begin
    if (LIMIT < 1)
      $error("LIMIT must be at least 1");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire          at_limit = (cnt_r == W'(LIMIT));

  // Saturates so only one pulse per continuous excursion
  assign cnt_nxt = !active ? '0 : (at_limit ? cnt_r : cnt_r + W'(1));
  assign expired = active && (cnt_r == W'(LIMIT - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

// ---- tb_bbfc_ctrl.sv ----
// Self-checking bench for bbfc_ctrl with a host model on the register side.
// Assumes the overvoltage timer is shortened to LIM cycles.
`timescale 1ns/10ps

module tb_bbfc_ctrl;
  localparam int LIM = 20;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  ovp_over = 1'b0;
  logic                  below = 1'b0;
  logic                  s1_low = 1'b0;
  logic                  s2_low = 1'b0;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata, m;
  logic                  reg_wr, reg_rd, shed_in, device_on;
  logic                  rd_v = 1'b0;
  logic [10:0]           mapper_code;
  logic [1:0]            string_en;
  bbfc_pkg::bbfc_boost_t boost;
  logic [7:0]            rd_q[$];
  logic [7:0]            tbl[5] = '{8'h3F, 8'h40, 8'h7F, 8'h80, 8'hFF};
  int                    miscompares = 0;
  int                    cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  bbfc_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .load_shed_input(shed_in));

  bbfc_ctrl #(.OVP_LIMIT(LIM)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .load_shed_input(shed_in), .ovp_over(ovp_over), .ovp_below_hyst(below),
    .string_one_sink_low(s1_low), .string_two_sink_low(s2_low), .mapper_code(mapper_code),
    .string_en(string_en), .device_on(device_on), .boost(boost));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic fail(input string s);
    miscompares++;
    $display("wrong value at %0t: %s", $time, s);
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string s);
    cmp_count++;
    if (got !== exp) fail(s);
  endtask

  // Read data is due exactly one cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rd_v)
    begin
      cmp_count++;
      if (rd_q.size() == 0) fail("unexpected read");
      else if (reg_rdata !== rd_q.pop_front()) fail("read data");
    end
    rd_v <= reg_rd;
  end

  task automatic rdexp(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    host.rd(a);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic ovp_hold(input int n);
    @(posedge ref_clk);
    ovp_over <= 1'b1;
    repeat (n) @(posedge ref_clk);
    ovp_over <= 1'b0;
    below <= 1'b1;
    @(posedge ref_clk);
    below <= 1'b0;
  endtask

  function automatic logic [1:0] efreq(input logic [7:0] v, hi, lo);
    if (hi == 8'h00 && lo == 8'h00) return bbfc_pkg::BBFC_F500K;
    if (v < lo) return bbfc_pkg::BBFC_F250K;
    return (v >= hi) ? bbfc_pkg::BBFC_F1M : bbfc_pkg::BBFC_F500K;
  endfunction

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h2b7636ce));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    chk(11'(string_en), 11'h003, "reset strings");
    rdexp(bbfc_pkg::ADDR_ENABLE, 8'h07);
    rdexp(8'h20, 8'h00);
    host.set_inductor(1'b1);
    tick(1);
    chk(11'(boost.min_ind), 11'h001, "min inductor");
    host.wr(bbfc_pkg::ADDR_BOOST, 8'h60);
    tick(1);
    chk(11'(boost.freq), 11'(bbfc_pkg::BBFC_F1M), "fixed 1M");
    chk(11'(boost.shift), 11'h001, "shift");
    host.wr(bbfc_pkg::ADDR_AF_HIGH, 8'h80);
    host.wr(bbfc_pkg::ADDR_AF_LOW, 8'h40);
    for (int i = 0; i < 8; i++)
    begin
      m = (i < 5) ? tbl[i] : 8'($urandom);
      host.wr(bbfc_pkg::ADDR_BRT_MSB, m);
      tick(1);
      chk(11'(boost.freq), 11'(efreq(m, 8'h80, 8'h40)), "auto freq");
      chk(11'(boost.duty_half), 11'(m < 8'h40), "duty limit");
    end
    host.wr(bbfc_pkg::ADDR_AF_HIGH, 8'h00);
    host.wr(bbfc_pkg::ADDR_BRT_MSB, 8'h10);
    tick(1);
    chk(11'(boost.freq), 11'(bbfc_pkg::BBFC_F250K), "low only");
    host.wr(bbfc_pkg::ADDR_AF_LOW, 8'h00);
    host.wr(bbfc_pkg::ADDR_BOOST, 8'h00);
    tick(1);
    chk(11'(boost.freq), 11'(bbfc_pkg::BBFC_F500K), "auto off");
    host.wr(bbfc_pkg::ADDR_BRT_LSB, 8'h05);
    host.wr(bbfc_pkg::ADDR_BRT_MSB, 8'hF0);
    host.wr(bbfc_pkg::ADDR_SHED_THR, 8'h40);
    tick(1);
    chk(mapper_code, 11'h785, "brightness");
    host.shed(1'b1);
    tick(1);
    chk(mapper_code, 11'h200, "shed code");
    host.shed(1'b0);
    tick(1);
    chk(mapper_code, 11'h785, "shed release");
    host.wr(bbfc_pkg::ADDR_SHED_THR, 8'hF8);
    host.shed(1'b1);
    tick(1);
    chk(mapper_code, 11'h785, "shed raise refused");
    host.wr(bbfc_pkg::ADDR_SHED_THR, 8'h40);
    host.wr(bbfc_pkg::ADDR_BRT_CTRL, 8'h01);
    tick(1);
    chk(mapper_code, 11'h785, "inverted, pin high");
    host.shed(1'b0);
    tick(1);
    chk(mapper_code, 11'h200, "inverted, pin low");
    host.wr(bbfc_pkg::ADDR_BRT_CTRL, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      host.wr(bbfc_pkg::ADDR_BOOST, 8'(i << 2));
      tick(1);
      chk(11'(boost.ovp_level), 11'(i), "ovp level");
    end
    @(posedge ref_clk);
    ovp_over <= 1'b1;
    tick(1);
    chk(11'(boost.run), 11'h000, "hold");
    @(posedge ref_clk);
    ovp_over <= 1'b0;
    below <= 1'b1;
    tick(1);
    chk(11'(boost.run), 11'h001, "resume");
    @(posedge ref_clk);
    below <= 1'b0;
    ovp_hold(LIM + 5);
    chk(11'(device_on), 11'h001, "report only");
    rdexp(bbfc_pkg::ADDR_FAULT, 8'h01);
    rdexp(bbfc_pkg::ADDR_FAULT, 8'h00);
    s1_low <= 1'b1;
    repeat (3) ovp_hold(2);
    rdexp(bbfc_pkg::ADDR_FAULT, 8'h11);
    s1_low <= 1'b0;
    host.open_test();
    s2_low <= 1'b1;
    ovp_hold(LIM + 5);
    rdexp(bbfc_pkg::ADDR_FAULT, 8'h11);
    s2_low <= 1'b0;
    host.wr(bbfc_pkg::ADDR_FAULT_CTL, 8'h01);
    ovp_hold(LIM + 5);
    tick(1);
    chk(11'(device_on), 11'h000, "shutdown");
    host.wr(bbfc_pkg::ADDR_ENABLE, 8'h07);
    tick(1);
    chk(11'(device_on), 11'h000, "re-enable refused");
    rdexp(bbfc_pkg::ADDR_FAULT, 8'h01);
    host.wr(bbfc_pkg::ADDR_ENABLE, 8'h07);
    tick(1);
    chk(11'(device_on), 11'h001, "re-enable after read");
    tick(3);
    close_out();
  end

  // Whole run is a few hundred cycles; this cuts a hang short
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
